// ===== verilog/ssw_pkg.sv
// shared constants and types of the supply supervisor with watchdog
// assumes a single 20 MHz time-base clock for both ends
package ssw_pkg;

  // time base
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PER_US = CLK_HZ / 1_000_000;

  // reset hold time, least value, in ms
  localparam int RESET_HOLD_MS = 140;
  localparam int HOLD_CYC = CLK_HZ / 1000 * RESET_HOLD_MS;

  // watchdog period, nominal, and its least value, in ms
  localparam int WD_PERIOD_MS = 1500;
  localparam int WD_PERIOD_MIN_MS = 1120;
  localparam int WD_CYC = CLK_HZ / 1000 * WD_PERIOD_MS;

  // internal service driver: low for 7/8 of the period
  localparam int DRV_LOW_NUM = 7;
  localparam int DRV_LOW_DEN = 8;

  // shortest watchdog pulse the device must catch (longest time: round down)
  localparam int WDI_PULSE_NS = 50;
  localparam int WDI_PULSE_CYC = (WDI_PULSE_NS * CLK_PER_US / 1000 < 1) ? 1 : WDI_PULSE_NS * CLK_PER_US / 1000;

  // least watchdog level hold by the processor (least time: round up)
  localparam int WDI_HOLD_NS = 20;
  localparam int WDI_HOLD_CYC = (WDI_HOLD_NS * CLK_PER_US + 999) / 1000;

  // manual reset glitch rejection (round down) and least press (round up)
  localparam int MR_REJECT_NS = 90;
  localparam int MR_REJECT_CYC = (MR_REJECT_NS * CLK_PER_US / 1000 < 1) ? 1 : MR_REJECT_NS * CLK_PER_US / 1000;
  localparam int MR_MIN_US = 1;
  localparam int MR_MIN_CYC = MR_MIN_US * CLK_PER_US;

  // processor service interval, kept below the least watchdog period
  localparam int SVC_PERIOD_MS = 1000;
  localparam int SVC_CYC = CLK_HZ / 1000 * SVC_PERIOD_MS;

  // reset sequencer states
  typedef enum logic [1:0] {ST_ASSERT, ST_HOLD, ST_RUN} ssw_state_t;

endpackage

// ===== verilog/ssw_if.sv
// pin-level link between the supervisor and the supervised processor
// resolves the shared watchdog pin and the pulled-up manual reset pin
`timescale 1ns/1ps
`default_nettype none

interface ssw_if;
  logic wdi_host;    // processor drive of the watchdog pin
  logic wdi_host_oe; // processor drives the watchdog pin
  logic wdi_drv;     // device internal service driver level
  logic wdi_drv_oe;  // internal driver enabled (weak)
  logic watchdog_service_in;         // resolved watchdog pin level
  logic mr_oe;       // switch or driver pulls manual reset low
  logic mr_n;        // resolved manual reset pin, active low
  logic sys_reset;   // reset output toward the processor

  // strong external drive wins over the weak internal driver
  assign watchdog_service_in = wdi_host_oe ? wdi_host : (wdi_drv_oe ? wdi_drv : 1'b0);
  // internal pull-up keeps the pin high when nobody pulls
  assign mr_n = ~mr_oe;

  modport dev (input watchdog_service_in, input mr_n, output wdi_drv, output wdi_drv_oe, output sys_reset);
  modport hst (output wdi_host, output wdi_host_oe, output mr_oe, input sys_reset);
endinterface

`default_nettype wire

// ===== verilog/ssw_dev.sv
// supervisor end: reset sequencer, watchdog timer, internal service driver
// assumes the ssw_if link and a supply-low indication from an analog comparator
`timescale 1ns/1ps
`default_nettype none

module ssw_dev
  import ssw_pkg::*;
#(
  parameter bit RST_ACTIVE_HIGH = 1'b0, // 0: active-low output
  parameter int HOLD_CYCLES = HOLD_CYC, // reset hold length
  parameter int WD_CYCLES = WD_CYC      // watchdog period length
)(
  input wire logic i_ref_clk,    // 20 MHz time base
  input wire logic i_rstn,       // synchronous reset, active low
  input wire logic i_supply_low, // supply below trip threshold
  ssw_if.dev lnk,                // pins toward the processor
  output logic o_in_reset,       // reset asserted, for any cause
  output logic o_wd_expired      // one-cycle pulse on watchdog expiry
);

  localparam int HW = $clog2(HOLD_CYCLES + 1);
  localparam int WW = $clog2(WD_CYCLES + 1);
  localparam int MW = $clog2(MR_REJECT_CYC + 2);
  localparam int DRV_LOW_CYCLES = WD_CYCLES / DRV_LOW_DEN * DRV_LOW_NUM;

  // all state in one record
  typedef struct packed {
    logic [1:0] sync_wdi;   // [0] first stage, [1] second stage
    logic [1:0] sync_mr;
    logic [1:0] sync_lv;
    logic wdi_last;         // last synchronised watchdog level
    logic [MW-1:0] mr_low;  // consecutive low samples, saturating
    ssw_state_t state;
    logic [HW-1:0] hold_cnt;
    logic [WW-1:0] wd_cnt;
    logic [WW-1:0] drv_cnt;
    logic drv;
    logic drv_oe;
    logic rst_out;
    logic in_reset;
    logic expired;
  } ssw_dev_t;

  ssw_dev_t r;
  ssw_dev_t next_r;

  logic mr_cause;
  logic lv_cause;
  logic wdi_toggle;
  logic wd_expire;
  logic next_in_reset;

  // cause decode from the second synchroniser stages only
  always_comb
  begin
    lv_cause = r.sync_lv[1];
    // a low must outlast the rejection window to count
    mr_cause = (r.mr_low == MW'(MR_REJECT_CYC + 1));
    wdi_toggle = r.sync_wdi[1] ^ r.wdi_last;
    wd_expire = (r.state == ST_RUN) && (r.wd_cnt == WW'(WD_CYCLES - 1));
  end

  // next-state logic
  always_comb
  begin
    next_r = r;

    // two-flop synchronisers; a 50 ns pulse is one full clock, so it is sampled
    next_r.sync_wdi = {r.sync_wdi[0], lnk.watchdog_service_in};
    next_r.sync_mr = {r.sync_mr[0], lnk.mr_n};
    next_r.sync_lv = {r.sync_lv[0], i_supply_low};
    next_r.wdi_last = r.sync_wdi[1];

    // glitch filter: count consecutive low samples, saturating
    if (r.sync_mr[1])
    begin
      next_r.mr_low = '0;
    end
    else if (r.mr_low != MW'(MR_REJECT_CYC + 1))
    begin
      next_r.mr_low = r.mr_low + MW'(1);
    end

    // reset sequencer; any live cause restarts the hold from zero,
    // so contact bounce only stretches one reset, never splits it
    if (lv_cause || mr_cause)
    begin
      next_r.state = ST_ASSERT;
      next_r.hold_cnt = '0;
    end
    else
    begin
      unique case (r.state)
        ST_ASSERT:
        begin
          next_r.state = ST_HOLD;
          next_r.hold_cnt = '0;
        end
        ST_HOLD:
        begin
          // hold time counted on the time base, then release
          if (r.hold_cnt == HW'(HOLD_CYCLES - 1))
          begin
            next_r.state = ST_RUN;
          end
          else
          begin
            next_r.hold_cnt = r.hold_cnt + HW'(1);
          end
        end
        ST_RUN:
        begin
          // expiry starts a full hold period
          if (wd_expire)
          begin
            next_r.state = ST_HOLD;
            next_r.hold_cnt = '0;
          end
        end
        default:
        begin
          next_r.state = ST_ASSERT;
          next_r.hold_cnt = '0;
        end
      endcase
    end

    next_in_reset = (next_r.state != ST_RUN);

    // watchdog timer: cleared while in reset, restarts from zero on release
    if (next_in_reset || r.state != ST_RUN)
    begin
      next_r.wd_cnt = '0;
    end
    else if (wdi_toggle)
    begin
      next_r.wd_cnt = '0;
    end
    else
    begin
      next_r.wd_cnt = r.wd_cnt + WW'(1);
    end

    // internal service driver: low for 7/8 of the period, high for the rest;
    // aligned to the watchdog start so its rising edge lands before expiry
    if (next_in_reset)
    begin
      next_r.drv_cnt = '0;
    end
    else if (r.drv_cnt == WW'(WD_CYCLES - 1))
    begin
      next_r.drv_cnt = '0;
    end
    else
    begin
      next_r.drv_cnt = r.drv_cnt + WW'(1);
    end
    next_r.drv = (next_r.drv_cnt >= WW'(DRV_LOW_CYCLES));
    // weak driver stays on; a strong outside drive overrides it
    next_r.drv_oe = 1'b1;

    // output polarity chosen at build time, timing identical
    next_r.rst_out = RST_ACTIVE_HIGH ? next_in_reset : ~next_in_reset;
    next_r.in_reset = next_in_reset;
    next_r.expired = wd_expire;
  end

  // state register; reset behaves as a power-up: reset asserted, hold running
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rstn)
    begin
      r <= '0;
      r.sync_mr <= 2'h3;
      r.state <= ST_HOLD;
      r.rst_out <= RST_ACTIVE_HIGH;
      r.in_reset <= 1'b1;
    end
    else
    begin
      r <= next_r;
    end
  end

  // outputs straight from the state register
  assign lnk.sys_reset = r.rst_out;
  assign lnk.wdi_drv = r.drv;
  assign lnk.wdi_drv_oe = r.drv_oe;
  assign o_in_reset = r.in_reset;
  assign o_wd_expired = r.expired;

endmodule

`default_nettype wire

// ===== verilog/ssw_host.sv
// processor end: services the watchdog and drives the manual reset switch
// assumes the ssw_if link; user side gives simple levels and pulses
`timescale 1ns/1ps
`default_nettype none

module ssw_host
  import ssw_pkg::*;
#(
  parameter bit RST_ACTIVE_HIGH = 1'b0, // must match the device build
  parameter int SVC_CYCLES = SVC_CYC,   // automatic service interval
  parameter int MR_CYCLES = MR_MIN_CYC  // least manual reset press
)(
  input wire logic i_ref_clk,      // 20 MHz time base
  input wire logic i_rstn,         // synchronous reset, active low
  input wire logic i_kick,         // pulse: toggle the watchdog pin now
  input wire logic i_auto_service, // level: toggle every service interval
  input wire logic i_wd_disable,   // level: release the watchdog pin
  input wire logic i_mr_press,     // level or pulse: press the switch
  ssw_if.hst lnk,                  // pins toward the supervisor
  output logic o_cpu_in_reset,     // processor sees reset
  output logic o_mr_active         // manual reset pin pulled low
);

  localparam int SW = $clog2(SVC_CYCLES + 1);
  localparam int PW = $clog2(MR_CYCLES + 1);

  typedef struct packed {
    logic [SW-1:0] svc_cnt;
    logic wdi_lvl;
    logic wdi_oe;
    logic [PW-1:0] mr_cnt;
    logic mr_oe;
    logic in_reset;
  } ssw_host_t;

  ssw_host_t r;
  ssw_host_t next_r;
  logic cpu_reset;

  always_comb
  begin
    next_r = r;
    cpu_reset = (lnk.sys_reset == RST_ACTIVE_HIGH);
    next_r.in_reset = cpu_reset;

    // a processor in reset runs no code, so service stops and restarts
    if (cpu_reset)
    begin
      next_r.svc_cnt = '0;
    end
    else if (i_kick || (i_auto_service && r.svc_cnt == SW'(SVC_CYCLES - 1)))
    begin
      // each level stands at least one clock, above the 20 ns minimum
      next_r.wdi_lvl = ~r.wdi_lvl;
      next_r.svc_cnt = '0;
    end
    else if (i_auto_service)
    begin
      next_r.svc_cnt = r.svc_cnt + SW'(1);
    end

    // releasing the pin hands it to the internal driver
    next_r.wdi_oe = ~i_wd_disable;

    // press is stretched to the least guaranteed length
    if (i_mr_press)
    begin
      next_r.mr_cnt = PW'(MR_CYCLES);
    end
    else if (r.mr_cnt != '0)
    begin
      next_r.mr_cnt = r.mr_cnt - PW'(1);
    end
    next_r.mr_oe = (next_r.mr_cnt != '0);
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rstn)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign lnk.wdi_host = r.wdi_lvl;
  assign lnk.wdi_host_oe = r.wdi_oe;
  assign lnk.mr_oe = r.mr_oe;
  assign o_cpu_in_reset = r.in_reset;
  assign o_mr_active = r.mr_oe;

endmodule

`default_nettype wire

// ===== verification/ssw_assertions.sv
// concurrent checks on the pins between supervisor and processor
// assumes the 20 MHz time base; reset polarity follows RST_ACTIVE_HIGH
`timescale 1ns/1ps
`default_nettype none

module ssw_assertions
  import ssw_pkg::*;
#(
  parameter bit RST_ACTIVE_HIGH = 1'b0, // output polarity
  parameter int HOLD_CYCLES = HOLD_CYC, // reset hold length
  parameter int WD_CYCLES = WD_CYC      // watchdog period length
)(
  input wire logic i_ref_clk,    // time base
  input wire logic i_rstn,       // synchronous reset, active low
  input wire logic i_supply_low, // supply below trip threshold
  input wire logic watchdog_service_in,          // resolved watchdog pin
  input wire logic wdi_host_oe,  // processor drives watchdog pin
  input wire logic wdi_drv,      // internal driver level
  input wire logic wdi_drv_oe,   // internal driver enabled
  input wire logic mr_oe,        // manual reset pulled low
  input wire logic sys_reset     // reset output
);
  localparam int WD_MAX = WD_CYCLES + 6;
  localparam int WD_EARLY = WD_CYCLES - 8;
  localparam int LO_MIN = WD_CYCLES * DRV_LOW_NUM / DRV_LOW_DEN - 3;
  localparam int LO_MAX = WD_CYCLES * DRV_LOW_NUM / DRV_LOW_DEN + 3;
  logic act;
  logic wdi_q;
  int idle_cnt = 0;
  int act_cnt = 0;
  int drv_lo = 0;
  int open_cnt = 0;

  assign act = (sys_reset == RST_ACTIVE_HIGH);

  // run lengths; pin edges count as service, asserted reset clears all but act_cnt, which counts it
  always_ff @(posedge i_ref_clk)
  begin
    wdi_q <= watchdog_service_in;
    idle_cnt <= (act || watchdog_service_in != wdi_q) ? 0 : idle_cnt + 1;
    // cleared in reset so an unknown output before the first edge cannot stick
    act_cnt <= (!i_rstn || !act) ? 0 : act_cnt + 1;
    drv_lo <= (act || wdi_drv) ? 0 : drv_lo + 1;
    open_cnt <= (!i_rstn || act || wdi_host_oe || mr_oe || i_supply_low) ? 0 : open_cnt + 1;
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  // margin of 8 covers the input synchronisers
  sequence s_calm;
    (!mr_oe && !i_supply_low)[*8];
  endsequence
  sequence s_mr_held;
    mr_oe[*7];
  endsequence

  a_supply_asserts:
    assert property (i_supply_low[*6] |-> act) else $error("no reset on supply low");
  a_mr_asserts:
    assert property (s_mr_held |-> act) else $error("no reset on manual press");
  a_mr_hold:
    assert property ($fell(mr_oe) |-> act[*8]) else $error("reset dropped with press");
  a_hold_length:
    assert property (act ##1 !act |-> act_cnt >= HOLD_CYCLES) else $error("reset hold too short");
  a_wd_bound:
    assert property (idle_cnt <= WD_MAX) else $error("watchdog expiry missed");
  a_no_false_reset:
    assert property (s_calm ##0 (!act && idle_cnt < WD_EARLY) |=> !act) else $error("early reset");
  a_drv_enabled:
    assert property (!act |-> wdi_drv_oe) else $error("driver off while running");
  a_drv_low_part:
    assert property (!act && $rose(wdi_drv) |-> drv_lo >= LO_MIN && drv_lo <= LO_MAX)
    else $error("driver low part wrong");
  a_drv_high_part:
    assert property ($rose(wdi_drv) |=> (wdi_drv || act)[*4]) else $error("driver high too short");
  a_open_alive:
    assert property (open_cnt >= 40 |-> !act) else $error("open pin expired");
endmodule

`default_nettype wire

// ===== verification/ssw_bench.sv
// self-checking bench: supervisor and processor ends joined by ssw_if
// a second supervisor faces a bench driver that glitches its pins
`timescale 1ns/1ps
`default_nettype none

module ssw_bench;
  import ssw_pkg::*;
  localparam int HC = 20;
  localparam int WC = 64;
  logic clk, rstn, sup, kick, auto, dis, press;
  logic in_rst, wd_exp, cpu_rst, mr_act, in_rst_b, wd_exp_b, in_q, in_q2;
  int failures = 0, samples_checked = 0, seed = 16504, cyc = 0, n, m, rises = 0, expb = 0, pc = 0;
  ssw_if lnk ();
  ssw_if lnk_b ();

  ssw_dev #(.HOLD_CYCLES(HC), .WD_CYCLES(WC)) i_ssw_dev (.i_ref_clk(clk), .i_rstn(rstn),
    .i_supply_low(sup), .lnk(lnk), .o_in_reset(in_rst), .o_wd_expired(wd_exp));
  ssw_host #(.SVC_CYCLES(40), .MR_CYCLES(20)) i_ssw_host (.i_ref_clk(clk), .i_rstn(rstn),
    .i_kick(kick), .i_auto_service(auto), .i_wd_disable(dis), .i_mr_press(press), .lnk(lnk),
    .o_cpu_in_reset(cpu_rst), .o_mr_active(mr_act));
  ssw_dev #(.HOLD_CYCLES(HC), .WD_CYCLES(WC)) i_ssw_dev_b (.i_ref_clk(clk), .i_rstn(rstn),
    .i_supply_low(1'b0), .lnk(lnk_b), .o_in_reset(in_rst_b), .o_wd_expired(wd_exp_b));
  ssw_assertions #(.HOLD_CYCLES(HC), .WD_CYCLES(WC)) i_ssw_assertions (.i_ref_clk(clk),
    .i_rstn(rstn), .i_supply_low(sup), .watchdog_service_in(lnk.watchdog_service_in), .wdi_host_oe(lnk.wdi_host_oe),
    .wdi_drv(lnk.wdi_drv), .wdi_drv_oe(lnk.wdi_drv_oe), .mr_oe(lnk.mr_oe), .sys_reset(lnk.sys_reset));

  task automatic results;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic got, input logic exp, input string msg);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  // cycles that the model allows between a cause and its effect
  task automatic chk_rng(input int v, input int lo, input int hi, input string msg);
    chk(v >= lo && v <= hi, 1'b1, msg);
  endtask

  task automatic rst_len(output int len);
    len = 0;
    while (in_rst !== 1'b0 && len < 400)
    begin
      @(posedge clk);
      len++;
    end
  endtask

  task automatic exp_wait(output int len);
    len = 0;
    while (wd_exp !== 1'b1 && len < 200)
    begin
      @(posedge clk);
      len++;
    end
  endtask

  initial
  begin
    clk = 0;
    forever #25 clk = ~clk;
  end

  // timeout, reset edge count, processor view of reset
  always @(posedge clk)
  begin
    cyc++;
    in_q <= in_rst;
    in_q2 <= in_q;
    if (in_rst === 1'b1 && in_q === 1'b0) rises++;
    if (wd_exp_b === 1'b1) expb++;
    if (cyc > 24 && in_rst === in_q && in_q === in_q2) chk(cpu_rst, in_rst, "cpu reset view");
    if (cyc > 20000)
    begin
      failures++;
      results();
    end
  end

  // one-cycle (50 ns) service pulses on the second link
  always @(posedge clk)
  begin
    pc <= (pc == 29) ? 0 : pc + 1;
    lnk_b.wdi_host <= (pc == 29);
  end

  initial
  begin
    rstn = 0; sup = 0; kick = 0; auto = 0; dis = 0; press = 0;
    lnk_b.wdi_host_oe = 1; lnk_b.mr_oe = 0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rst_len(n); chk_rng(n, HC - 1, HC + 6, "power-up hold");
    auto <= 1'b1;
    repeat (400)
    begin
      @(posedge clk);
      kick <= ($random(seed) % 16) == 0;
      chk(in_rst, 1'b0, "serviced reset");
    end
    // stop service after one last kick, then expect expiry
    auto <= 1'b0; kick <= 1'b0;
    // short gap: last service plus gap must stay below the watchdog period
    repeat (20) @(posedge clk);
    kick <= 1'b1; @(posedge clk); kick <= 1'b0;
    exp_wait(n); chk_rng(n, WC - 2, WC + 6, "expiry time");
    kick <= 1'b1;
    @(posedge clk);
    rst_len(n); chk_rng(n, HC - 1, HC + 6, "expiry hold");
    kick <= 1'b0;
    exp_wait(n); chk_rng(n, WC - 3, WC + 8, "count from release");
    @(posedge clk);
    rst_len(n);
    dis <= 1'b1;
    repeat (300)
    begin
      @(posedge clk);
      chk(wd_exp, 1'b0, "open pin expiry");
    end
    dis <= 1'b0; auto <= 1'b1;
    repeat (5)
    begin
      sup <= 1'b1; n = 0;
      while (in_rst !== 1'b1 && n < 20)
      begin
        @(posedge clk);
        n++;
      end
      chk_rng(n, 1, 6, "supply assert");
      m = 1 + ($random(seed) & 15); repeat (m) @(posedge clk);
      sup <= 1'b0; @(posedge clk);
      rst_len(n); chk_rng(n, HC, HC + 8, "supply hold");
      repeat (10) @(posedge clk);
    end
    // bouncing contact must merge into one reset
    rises = 0;
    repeat (6)
    begin
      press <= 1'b1; m = 1 + ($random(seed) & 3); repeat (m) @(posedge clk);
      press <= 1'b0; m = 1 + ($random(seed) & 7); repeat (m) @(posedge clk);
    end
    while (mr_act !== 1'b0) @(posedge clk);
    rst_len(n); chk_rng(n, HC, HC + 8, "manual hold");
    chk(rises == 1, 1'b1, "bounce gives one reset");
    lnk_b.mr_oe <= 1'b1; @(posedge clk); lnk_b.mr_oe <= 1'b0;
    repeat (30)
    begin
      @(posedge clk);
      chk(in_rst_b, 1'b0, "glitch rejected");
    end
    lnk_b.mr_oe <= 1'b1; repeat (MR_MIN_CYC) @(posedge clk); lnk_b.mr_oe <= 1'b0;
    @(posedge clk); chk(in_rst_b, 1'b1, "least press resets");
    chk(expb == 0, 1'b1, "short pulses serviced");
    results();
  end
endmodule

`default_nettype wire
